/* File: hdl/sbu_lane_shift.sv */
/*
 * Byte lane former for a store-right: shifts the source word up by the
 * byte index and gives lane enables and store size.
 * Assumes a 4-byte word; purely combinational.
 */
`include "sbu_regs.svh"
module sbu_lane_shift (
    // source
    input wire logic [31:0] src,
    input wire logic [1:0] byte_idx,
    // formed store
    output logic [31:0] data,
    output logic [3:0] be,
    output logic [2:0] size
);
    always_comb begin
        data = src << {byte_idx, 3'h0};
        be = `SBU_ALL_LANES << byte_idx;
        size = `SBU_WORD_BYTES - {1'b0, byte_idx};
    end
endmodule : sbu_lane_shift

/* File: hdl/sbu_pkg.sv */
/*
 * Types of the store-right and barrier unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sbu_pkg;

    // ****************************************************
    // operations and answers
    // ****************************************************
    typedef enum logic [1:0] {
        SBU_OP_STORE_RIGHT = 2'h0,
        SBU_OP_STORE_RIGHT_UM = 2'h1,
        SBU_OP_STORE_FP_IDX = 2'h2,
        SBU_OP_BARRIER = 2'h3
    } sbu_op_e;

    typedef enum logic [1:0] {
        SBU_EXC_NONE = 2'h0,
        SBU_EXC_ADDR = 2'h1,
        SBU_EXC_RESV = 2'h2,
        SBU_EXC_CPU = 2'h3
    } sbu_exc_e;

    typedef enum logic [2:0] {
        SBU_ST_IDLE = 3'h1,
        SBU_ST_STORE = 3'h2,
        SBU_ST_BAR = 3'h4
    } sbu_state_e;

    typedef struct packed {
        sbu_state_e st;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] be;
        logic [2:0] size;
        logic user_map;
        logic exc_v;
        sbu_exc_e exc;
        logic bar_cmp;
        logic [1:0] old_mask;
        logic [1:0] young_mask;
        logic done;
    } sbu_state_s;

endpackage : sbu_pkg

/* File: hdl/sbu_regs.svh */
/*
 * Constants of the store-right and barrier unit: instruction field
 * positions, barrier type codes, offsets and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SBU_REGS_SVH
`define SBU_REGS_SVH

// ****************************************************
// barrier type field
// ****************************************************
`define SBU_STYPE_HI 10
`define SBU_STYPE_LO 6
`define SBU_STYPE_FULL 5'h00
`define SBU_STYPE_WMB 5'h04
`define SBU_STYPE_MB 5'h10
`define SBU_STYPE_ACQ 5'h11
`define SBU_STYPE_REL 5'h12
`define SBU_STYPE_RMB 5'h13

// ****************************************************
// offsets and sizes
// ****************************************************
`define SBU_OFF_UM_W 9
`define SBU_WORD_BYTES 3'h4
`define SBU_ALL_LANES 4'hF

// ****************************************************
// reset values
// ****************************************************
`define SBU_RST_ADDR 32'h0000_0000
`define SBU_RST_DATA 32'h0000_0000
`define SBU_RST_BE 4'h0
`define SBU_RST_SIZE 3'h0

`endif

/* File: hdl/sbu_store_barrier.sv */
/*
 * Store-right (plain and user-mapped), indexed FP word store and memory
 * barrier sequencing for a load/store unit.
 * Assumes translation, TLB faults, bus and watch errors are handled by the
 * memory side; pending counts come from the load/store queues and count
 * only uncached or cached-coherent accesses, cache and prefetch included.
 */
`include "sbu_regs.svh"
module sbu_store_barrier #(
    parameter int unsigned ADDR_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // request
    input wire logic req_valid,
    output logic req_ready,
    input wire sbu_pkg::sbu_op_e req_op,
    input wire logic [ADDR_W-1:0] req_base,
    input wire logic [ADDR_W-1:0] req_index,
    input wire logic [15:0] req_offset,
    input wire logic [31:0] req_rt,
    input wire logic [63:0] req_fp,
    input wire logic [31:0] req_instr,
    // mode and configuration
    input wire logic cpu_byte_order_flag,
    input wire logic memory_byte_order_flag,
    input wire logic user_byte_swap_flag,
    input wire logic extended_vaddr_present,
    input wire logic cp0_access_enabled,
    input wire logic mapped_user_kernel_segment,
    input wire logic unmapped_user_kernel_segment,
    input wire logic mapped_user_supervisor_segment,
    input wire logic arch_release2,
    input wire logic core_wide,
    input wire logic fpu_present,
    // store to memory
    output logic st_valid,
    input wire logic st_ready,
    output logic [31:0] st_addr,
    output logic [31:0] st_data,
    output logic [3:0] st_be,
    output logic [2:0] st_size,
    output logic st_user_map,
    // exception
    output logic exc_valid,
    output sbu_pkg::sbu_exc_e exc_code,
    // barrier
    input wire logic older_sync_loads_pending,
    input wire logic older_sync_stores_pending,
    input wire logic older_loads_unordered,
    input wire logic older_stores_unordered,
    output logic stall_young_loads,
    output logic stall_young_stores,
    output logic sync_done
);
    // ****************************************************
    // elaboration check
    // ****************************************************
    if (ADDR_W != 32) begin : g_bad_width
        $error("sbu_store_barrier serves 32-bit addresses only");
    end

    sbu_pkg::sbu_state_s s_q;
    sbu_pkg::sbu_state_s s_d;
    logic [31:0] off_ext;
    logic [31:0] ea;
    logic [1:0] byte_idx;
    logic [31:0] sh_data;
    logic [3:0] sh_be;
    logic [2:0] sh_size;
    logic [4:0] stype;
    logic seg_ok;
    logic take;
    logic bar_met;

    // ****************************************************
    // address and lane forming
    // ****************************************************
    assign take = req_valid && req_ready;
    assign stype = req_instr[`SBU_STYPE_HI:`SBU_STYPE_LO];
    assign seg_ok = mapped_user_kernel_segment
        || unmapped_user_kernel_segment || mapped_user_supervisor_segment;

    always_comb begin
        if (req_op == sbu_pkg::SBU_OP_STORE_RIGHT_UM) begin
            off_ext = {{23{req_offset[8]}}, req_offset[8:0]};
        end else begin
            off_ext = {{16{req_offset[15]}}, req_offset};
        end
        if (req_op == sbu_pkg::SBU_OP_STORE_FP_IDX) begin
            ea = req_base + req_index;
        end else begin
            ea = req_base + off_ext;
        end
    end

    // index from address and byte order
    assign byte_idx = ea[1:0] ^ {2{cpu_byte_order_flag}};

    sbu_lane_shift u_lanes (
        .src(req_rt),
        .byte_idx(byte_idx),
        .data(sh_data),
        .be(sh_be),
        .size(sh_size)
    );

    // completion needs older accesses fully performed
    // ordering needs them only past the ordering point
    always_comb begin
        if (s_q.bar_cmp) begin
            bar_met = !(s_q.old_mask[0] && older_sync_loads_pending)
                && !(s_q.old_mask[1] && older_sync_stores_pending);
        end else begin
            bar_met = !(s_q.old_mask[0] && older_loads_unordered)
                && !(s_q.old_mask[1] && older_stores_unordered);
        end
    end

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        s_d = s_q;
        s_d.exc_v = 1'b0;
        s_d.exc = sbu_pkg::SBU_EXC_NONE;
        s_d.done = 1'b0;
        unique case (s_q.st)
            sbu_pkg::SBU_ST_IDLE: begin
                if (take) begin
                    s_d.user_map = 1'b0;
                    unique case (req_op)
                        sbu_pkg::SBU_OP_STORE_RIGHT,
                        sbu_pkg::SBU_OP_STORE_RIGHT_UM: begin
                            // user-mapped form needs cp0 access and a user-kernel or user-supervisor segment
                            if (req_op == sbu_pkg::SBU_OP_STORE_RIGHT_UM
                                    && !extended_vaddr_present) begin
                                s_d.exc_v = 1'b1;
                                s_d.exc = sbu_pkg::SBU_EXC_RESV;
                            end else if (req_op ==
                                    sbu_pkg::SBU_OP_STORE_RIGHT_UM
                                    && !(cp0_access_enabled && seg_ok)) begin
                                s_d.exc_v = 1'b1;
                                s_d.exc = sbu_pkg::SBU_EXC_CPU;
                            end else begin
                                s_d.st = sbu_pkg::SBU_ST_STORE;
                                s_d.data = sh_data;
                                s_d.be = sh_be;
                                s_d.size = sh_size;
                                // little-endian memory takes the word address
                                s_d.addr = memory_byte_order_flag
                                    ? {ea[31:2],
                                       ea[1:0] ^ {2{user_byte_swap_flag}}}
                                    : {ea[31:2], 2'h0};
                                s_d.user_map = (req_op ==
                                    sbu_pkg::SBU_OP_STORE_RIGHT_UM)
                                    && mapped_user_kernel_segment;
                            end
                        end
                        sbu_pkg::SBU_OP_STORE_FP_IDX: begin
                            if (!(arch_release2 || core_wide)) begin
                                s_d.exc_v = 1'b1;
                                s_d.exc = sbu_pkg::SBU_EXC_RESV;
                            end else if (!fpu_present) begin
                                s_d.exc_v = 1'b1;
                                s_d.exc = sbu_pkg::SBU_EXC_CPU;
                            end else if (ea[1:0] != 2'h0) begin
                                s_d.exc_v = 1'b1;
                                s_d.exc = sbu_pkg::SBU_EXC_ADDR;
                            end else begin
                                s_d.st = sbu_pkg::SBU_ST_STORE;
                                s_d.addr = ea;
                                s_d.data = req_fp[31:0];
                                s_d.be = `SBU_ALL_LANES;
                                s_d.size = `SBU_WORD_BYTES;
                            end
                        end
                        sbu_pkg::SBU_OP_BARRIER: begin
                            s_d.st = sbu_pkg::SBU_ST_BAR;
                            // type zero, reserved and unused
                            // codes all become a full completion barrier
                            // fetch path is not held
                            unique case (stype)
                                `SBU_STYPE_WMB: begin
                                    s_d.bar_cmp = 1'b0;
                                    s_d.old_mask = 2'h2;
                                    s_d.young_mask = 2'h2;
                                end
                                `SBU_STYPE_MB: begin
                                    s_d.bar_cmp = 1'b0;
                                    s_d.old_mask = 2'h3;
                                    s_d.young_mask = 2'h3;
                                end
                                `SBU_STYPE_ACQ: begin
                                    s_d.bar_cmp = 1'b0;
                                    s_d.old_mask = 2'h1;
                                    s_d.young_mask = 2'h3;
                                end
                                `SBU_STYPE_REL: begin
                                    s_d.bar_cmp = 1'b0;
                                    s_d.old_mask = 2'h3;
                                    s_d.young_mask = 2'h2;
                                end
                                `SBU_STYPE_RMB: begin
                                    s_d.bar_cmp = 1'b0;
                                    s_d.old_mask = 2'h1;
                                    s_d.young_mask = 2'h1;
                                end
                                default: begin
                                    s_d.bar_cmp = 1'b1;
                                    s_d.old_mask = 2'h3;
                                    s_d.young_mask = 2'h3;
                                end
                            endcase
                        end
                    endcase
                end
            end
            sbu_pkg::SBU_ST_STORE: begin
                if (st_ready) begin
                    s_d.st = sbu_pkg::SBU_ST_IDLE;
                end
            end
            sbu_pkg::SBU_ST_BAR: begin
                // pending counts include cache and prefetch
                if (bar_met) begin
                    s_d.st = sbu_pkg::SBU_ST_IDLE;
                    s_d.done = 1'b1;
                end
            end
            default: begin
                s_d.st = sbu_pkg::SBU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: sbu_pkg::SBU_ST_IDLE, addr: `SBU_RST_ADDR,
                data: `SBU_RST_DATA, be: `SBU_RST_BE, size: `SBU_RST_SIZE,
                user_map: 1'b0, exc_v: 1'b0, exc: sbu_pkg::SBU_EXC_NONE,
                bar_cmp: 1'b0, old_mask: 2'h0, young_mask: 2'h0,
                done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign req_ready = (s_q.st == sbu_pkg::SBU_ST_IDLE);
    assign st_valid = (s_q.st == sbu_pkg::SBU_ST_STORE);
    assign st_addr = s_q.addr;
    assign st_data = s_q.data;
    assign st_be = s_q.be;
    assign st_size = s_q.size;
    assign st_user_map = s_q.user_map;
    assign exc_valid = s_q.exc_v;
    assign exc_code = s_q.exc;
    // hold younger synchronizable ops while barrier waits
    assign stall_young_loads = (s_q.st == sbu_pkg::SBU_ST_BAR)
        && s_q.young_mask[0];
    assign stall_young_stores = (s_q.st == sbu_pkg::SBU_ST_BAR)
        && s_q.young_mask[1];
    assign sync_done = s_q.done;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_take_swr;
        take && req_op == sbu_pkg::SBU_OP_STORE_RIGHT;
    endsequence
    sequence s_take_fp_misaligned;
        take && req_op == sbu_pkg::SBU_OP_STORE_FP_IDX
            && (arch_release2 || core_wide) && fpu_present
            && ea[1:0] != 2'h0;
    endsequence
    sequence s_cmp_blocked;
        s_q.st == sbu_pkg::SBU_ST_BAR && s_q.bar_cmp
            && (older_sync_loads_pending || older_sync_stores_pending);
    endsequence

    logic [2:0] exp_size;
    assign exp_size = `SBU_WORD_BYTES - {1'b0, byte_idx};

    chk_swr_size_idx: assert property (
        s_take_swr |=> st_valid && st_size == $past(exp_size))
        else $error("store-right size not word minus index");
    chk_be_count: assert property (
        st_valid |-> $countones(st_be) == 32'(st_size) && st_be[3])
        else $error("lane enables disagree with size");
    chk_fp_align: assert property (
        s_take_fp_misaligned |=> exc_valid
            && exc_code == sbu_pkg::SBU_EXC_ADDR && !st_valid)
        else $error("misaligned fp store not refused");
    chk_um_absent: assert property (
        take && req_op == sbu_pkg::SBU_OP_STORE_RIGHT_UM
            && !extended_vaddr_present
            |=> exc_valid && exc_code == sbu_pkg::SBU_EXC_RESV)
        else $error("user-mapped store-right without extended addressing");
    chk_um_cp0: assert property (
        take && req_op == sbu_pkg::SBU_OP_STORE_RIGHT_UM
            && extended_vaddr_present && !cp0_access_enabled
            |=> exc_valid && exc_code == sbu_pkg::SBU_EXC_CPU)
        else $error("user-mapped store-right without cp0 access");
    chk_store_hold: assert property (
        st_valid && !st_ready |=> st_valid && $stable(st_addr)
            && $stable(st_data) && $stable(st_be))
        else $error("store dropped before accepted");
    chk_full_barrier: assert property (
        take && req_op == sbu_pkg::SBU_OP_BARRIER
            && stype == `SBU_STYPE_FULL
            |=> stall_young_loads && stall_young_stores)
        else $error("type zero barrier did not stall both kinds");
    chk_cmp_wait: assert property (
        s_cmp_blocked |=> !sync_done && stall_young_loads)
        else $error("completion barrier retired early");
    chk_ord_wait: assert property (
        s_q.st == sbu_pkg::SBU_ST_BAR && !s_q.bar_cmp
            && s_q.old_mask[0] && older_loads_unordered
            |=> !sync_done)
        else $error("ordering barrier retired early");
    chk_bar_retire: assert property (
        sync_done |-> !stall_young_loads && !stall_young_stores
            && req_ready)
        else $error("stall held after barrier retired");
endmodule : sbu_store_barrier

/* File: tb/sbu_mem_model.sv */
/*
 * Memory-side model for the store-right and barrier unit: takes stores
 * after a set wait and holds older-access flags for a set count.
 * Assumes the unit's clock and active-low reset.
 */
module sbu_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // store side
    input wire logic st_valid,
    output logic st_ready,
    input wire logic [3:0] st_wait,
    // older access flags: st_unord, ld_unord, st_pend, ld_pend
    input wire logic pend_go,
    input wire logic [3:0] pend_mask,
    input wire logic [3:0] pend_len,
    output logic [3:0] pend
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    logic [3:0] left_q;
    // flags high while older ops in flight
    assign pend = (left_q != 4'h0) ? pend_mask : 4'h0;
    // slow memory: a store waits out st_wait cycles before acceptance
    assign st_ready = st_valid && (wait_q == 4'h0);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 4'h0;
            left_q <= 4'h0;
        end else begin
            wait_q <= (st_valid && !st_ready) ? wait_q - 4'h1 : st_wait;
            if (pend_go) begin
                left_q <= pend_len;
            end else if (left_q != 4'h0) begin
                left_q <= left_q - 4'h1;
            end
        end
    end
endmodule : sbu_mem_model

/* File: tb/tb_sbu_store_barrier.sv */
/*
 * Testbench of the store-right and barrier unit: store lanes, refusals,
 * FP indexed store and every barrier type against a memory-side model.
 * Assumes the design package and the model file are compiled first.
 */
module tb_sbu_store_barrier;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic pend_go = 1'b0;
    sbu_pkg::sbu_op_e req_op = sbu_pkg::SBU_OP_STORE_RIGHT;
    logic [31:0] req_base = 32'h0, req_index = 32'h0, req_rt = 32'h0;
    logic [31:0] req_instr = 32'h0, st_addr, st_data;
    logic [63:0] req_fp = 64'h0;
    logic [15:0] req_offset = 16'h0;
    // fpu, wide, rel2, mapped_user_supervisor_segment, unmapped_user_kernel_segment, mapped_user_kernel_segment, cp0, evp, swap, mem, cpu order
    logic [10:0] cfg = 11'h538;
    logic [3:0] st_wait = 4'h0, pend_mask = 4'h0, pend, st_be;
    logic [2:0] st_size;
    logic req_ready, st_valid, st_ready, st_user_map, exc_valid, sync_done;
    logic stall_young_loads, stall_young_stores;
    sbu_pkg::sbu_exc_e exc_code;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [10:0] rf_cfg [7] = '{11'h530, 11'h528, 11'h518, 11'h538,
        11'h538, 11'h438, 11'h138};
    logic [1:0] rf_idx [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
    logic [1:0] rf_code [7] = '{2'h2, 2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h3};
    // type, pending mask, slow, expected stalls {loads, stores}
    logic [11:0] bar_tab [11] = '{12'h01F, 12'h245, 12'h221, 12'h827,
        12'h8A7, 12'h8C3, 12'h945, 12'h9A6, 12'h9C2, 12'h097, 12'hA0F};

    sbu_store_barrier DUT (.clk, .rst_b, .req_valid, .req_ready, .req_op,
        .req_base, .req_index, .req_offset, .req_rt, .req_fp, .req_instr,
        .cpu_byte_order_flag(cfg[0]), .memory_byte_order_flag(cfg[1]),
        .user_byte_swap_flag(cfg[2]), .extended_vaddr_present(cfg[3]),
        .cp0_access_enabled(cfg[4]), .mapped_user_kernel_segment(cfg[5]),
        .unmapped_user_kernel_segment(cfg[6]),
        .mapped_user_supervisor_segment(cfg[7]), .arch_release2(cfg[8]),
        .core_wide(cfg[9]), .fpu_present(cfg[10]), .st_valid, .st_ready,
        .st_addr, .st_data, .st_be, .st_size, .st_user_map, .exc_valid,
        .exc_code, .older_sync_loads_pending(pend[0]),
        .older_sync_stores_pending(pend[1]), .older_loads_unordered(pend[2]),
        .older_stores_unordered(pend[3]), .stall_young_loads,
        .stall_young_stores, .sync_done);

    sbu_mem_model mem (.clk, .rst_b, .st_valid, .st_ready, .st_wait,
        .pend_go, .pend_mask, .pend_len(4'h5), .pend);

    always #2 clk = ~clk;

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // one request, taken at the second edge; returns in the answer cycle
    task automatic issue(input logic [1:0] op, input logic [10:0] c,
            input logic [31:0] base, idx, input logic [15:0] off,
            input logic [31:0] rt, ins, input logic [3:0] wt, pm);
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= sbu_pkg::sbu_op_e'(op);
        {cfg, req_base, req_index, req_offset} <= {c, base, idx, off};
        {req_rt, req_fp, req_instr} <= {rt, ~rt, rt, ins};
        {st_wait, pend_mask, pend_go} <= {wt, pm, 1'b1};
        @(negedge clk);
        check(req_ready, 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        pend_go <= 1'b0;
        @(negedge clk);
    endtask : issue

    task automatic expect_store(input logic [31:0] a, d,
            input logic [3:0] be, input logic [2:0] sz, input logic um);
        int n;
        n = 0;
        check(st_valid, 1'b1);
        check(exc_valid, 1'b0);
        check(st_addr, a);
        check(st_data, d);
        check(st_be, be);
        check(st_size, sz);
        check(st_user_map, um);
        while ({st_valid, st_ready} !== 2'b11 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(st_data, d);
        @(negedge clk);
        check({st_valid, req_ready}, 2'b01);
    endtask : expect_store

    task automatic t_store_right;
        logic [31:0] ea, a, b;
        logic [1:0] ix;
        for (int i = 0; i < 32; i++) begin
            b = 32'h2000_0100 | i[3:2];
            ea = b + (i[4] ? 32'hFFFF_FFFC : 32'hFFFF_FFF0);
            ix = ea[1:0] ^ {2{i[0]}};
            a = {ea[31:2], i[1] ? ea[1:0] ^ {2{i[0] ^ i[3]}} : 2'b00};
            issue({1'b0, i[4]}, 11'h538 | {i[0] ^ i[3], i[1:0]}, b, 32'h0,
                i[4] ? 16'h01FC : 16'hFFF0, 32'h8877_6655 + i, 32'h0,
                i[3:0], 4'h0);
            expect_store(a, (32'h8877_6655 + i) << (8 * ix), 4'hF << ix,
                3'h4 - ix, i[4]);
        end
    endtask : t_store_right

    task automatic t_refuse;
        for (int i = 0; i < 7; i++) begin
            issue(i < 3 ? 2'h1 : 2'h2, rf_cfg[i], 32'h3000_0000,
                {30'h0, rf_idx[i]}, 16'h0, 32'h1234_5678, 32'h0, 4'h0, 4'h0);
            check({exc_valid, st_valid}, 2'b10);
            check(exc_code, rf_code[i]);
            @(negedge clk);
            check(exc_valid, 1'b0);
        end
    endtask : t_refuse

    task automatic t_fp_store;
        for (int i = 0; i < 2; i++) begin
            issue(2'h2, i ? 11'h638 : 11'h538, 32'h3000_0010, 32'h0000_0FF4,
                16'hFFFF, 32'hCAFE_0004 + i, 32'h0, 4'h2, 4'h0);
            expect_store(32'h3000_1004, 32'hCAFE_0004 + i, 4'hF, 3'h4,
                1'b0);
        end
    endtask : t_fp_store

    task automatic t_barrier;
        int n;
        // entry 0 is the full barrier software puts at mode changes
        for (int i = 0; i < 11; i++) begin
            issue(2'h3, 11'h538, 32'h0, 32'h0, 16'h0, 32'h0,
                {21'h0, bar_tab[i][11:7], 6'h0F}, 4'h0, bar_tab[i][6:3]);
            check({stall_young_loads, stall_young_stores},
                bar_tab[i][1:0]);
            n = 1;
            while (sync_done !== 1'b1 && n < 30) begin
                @(negedge clk);
                n++;
            end
            check(n > 4, bar_tab[i][2]);
            check({stall_young_loads, stall_young_stores, req_ready},
                3'b001);
        end
    endtask : t_barrier

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_store_right();
        t_refuse();
        t_fp_store();
        t_barrier();
        print_verdict();
    end
endmodule : tb_sbu_store_barrier
